// >>> logic/asr_map.svh
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
// ---------------------------------------------
// command codes
// ---------------------------------------------
`define ASR_CMD_WREN 8'h06
`define ASR_CMD_RDREG 8'h65
`define ASR_CMD_WRREG 8'h71
`define ASR_CMD_NONE 8'h00
// ---------------------------------------------
// register selectors and bit positions
// ---------------------------------------------
`define ASR_REG_SR1 8'h00
`define ASR_REG_SR2 8'h01
`define ASR_REG_NV 8'h02
`define ASR_BIT_BUSY 0
`define ASR_BIT_LATCH 1
`define ASR_BIT_PERR 5
`define ASR_NV_RST 8'h00
// ---------------------------------------------
// framing
// ---------------------------------------------
`define ASR_ADDR_BYTES 2'h3
`define ASR_ADDR_FIELD 2'h2
`define ASR_DUMMY_QPI 4'h1
`define ASR_DUMMY_SPI 4'h8
`define ASR_DUMMY_NA 4'hF
`define ASR_CPB_QPI 4'h2
`define ASR_CPB_SPI 4'h8
// ---------------------------------------------
// timing
// ---------------------------------------------
`define ASR_CLK_NS 10
`define ASR_HALF 8'h08
`define ASR_WR_TIME_NS 2000
`define ASR_WR_CYC ((`ASR_WR_TIME_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`endif

// >>> logic/asr_pkg.sv
package asr_pkg;
   typedef enum logic [2:0] {
      M_SPI, M_DUAL, M_QPI, M_QDTR, M_OCT, M_OCTDTR
   } asr_mode_t;
   typedef enum logic [1:0] {OP_WREN, OP_READ, OP_WRITE} asr_op_t;
   typedef enum logic [2:0] {D_CMD, D_ADDR, D_DUMMY, D_OUT, D_IN, D_SKIP} asr_dev_st_t;
   typedef enum logic [1:0] {H_IDLE, H_RUN, H_END, H_GAP} asr_host_st_t;
endpackage

// >>> logic/asr_link_if.sv
`timescale 1ns/1ps
interface asr_link_if;
   logic sclk;
   logic cs_n;
   logic [3:0] h_io_o;
   logic [3:0] h_io_oe;
   logic [3:0] d_io_o;
   logic [3:0] d_io_oe;
   logic [3:0] io;
   // wire level with pull-ups where nobody drives
   assign io = (h_io_oe & h_io_o) | (d_io_oe & d_io_o) | ~(h_io_oe | d_io_oe);
   modport host (output sclk, output cs_n, output h_io_o, output h_io_oe, input io);
   modport dev (input sclk, input cs_n, input io, output d_io_o, output d_io_oe);
endinterface

// >>> logic/asr_sync.sv
`timescale 1ns/1ps
module asr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_q <= RST;
         s2_q <= RST;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
      end
   end
   assign q_o = s2_q;
endmodule

// >>> logic/asr_dev.sv
// What this block does
// - accepts addressed write to a non-volatile register
// - three address bytes follow the command code
// - quad single-rate read has one dummy clock
// - addressed read refused in other wide modes
// - code 65h reads register at given address
// - busy-flag register ignores addressed writes
// - busy flag lives in status register 00h
// - busy flag bit 0, one while working
// - busy flag reached only by addressed commands
// - register selector is last address byte
// - write latch bit 1, set by 06h
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_dev (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   asr_link_if.dev link,
   input asr_pkg::asr_mode_t mode_i,
   input wire logic array_busy_i,
   output logic busy_o,
   output logic latch_o,
   output logic [7:0] nv_cfg_o
);
   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic sclk_s;
   logic csn_s;
   logic [3:0] io_s;
   logic sclk_p_q;
   logic rise;
   logic fall;
   logic qpi;
   logic spi;

   // resets to idle pins: clock low, deselected, lines pulled up
   asr_sync #(.W(6), .RST(6'h1F)) u_sync (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .d_i({link.sclk, link.cs_n, link.io}),
      .q_o({sclk_s, csn_s, io_s})
   );

   assign rise = sclk_s & ~sclk_p_q;
   assign fall = ~sclk_s & sclk_p_q;
   assign qpi = (mode_i == asr_pkg::M_QPI);
   assign spi = (mode_i == asr_pkg::M_SPI);

   // ---------------------------------------------
   // command state
   // ---------------------------------------------
   asr_pkg::asr_dev_st_t st_q;
   asr_pkg::asr_dev_st_t st_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [1:0] byt_q;
   logic [1:0] byt_d;
   logic [7:0] rsel_q;
   logic [7:0] rsel_d;
   logic rd_q;
   logic rd_d;
   logic [7:0] obuf_q;
   logic [7:0] obuf_d;
   logic [3:0] io_q;
   logic [3:0] io_d;
   logic latch_q;
   logic latch_d;
   logic [7:0] nv_q;
   logic [7:0] nv_d;
   logic [7:0] wdat_q;
   logic [7:0] wdat_d;
   logic pend_q;
   logic pend_d;
   logic [15:0] wcnt_q;
   logic [15:0] wcnt_d;

   logic [3:0] cpb;
   logic [3:0] dummy;
   logic [7:0] shifted;
   logic byte_done;
   logic busy;
   logic [7:0] regval;

   assign cpb = qpi ? `ASR_CPB_QPI : `ASR_CPB_SPI;
   assign dummy = qpi ? `ASR_DUMMY_QPI : `ASR_DUMMY_SPI;
   assign shifted = qpi ? {sh_q[3:0], io_s} : {sh_q[6:0], io_s[0]};
   assign byte_done = (cnt_q == cpb - 4'h1);
   assign busy = (wcnt_q != 16'h0000) | array_busy_i;

   // register read mux
   always_comb begin
      regval = 8'h00;
      case (rsel_q)
         `ASR_REG_SR1: begin
            regval[`ASR_BIT_BUSY] = busy;
            regval[`ASR_BIT_LATCH] = latch_q;
         end
         `ASR_REG_SR2: regval[`ASR_BIT_PERR] = 1'b0;
         `ASR_REG_NV: regval = nv_q;
         default: regval = 8'h00;
      endcase
   end

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      byt_d = byt_q;
      rsel_d = rsel_q;
      rd_d = rd_q;
      obuf_d = obuf_q;
      io_d = io_q;
      latch_d = latch_q;
      nv_d = nv_q;
      wdat_d = wdat_q;
      pend_d = pend_q;
      wcnt_d = wcnt_q;
      // internal write timer; latch drops when it ends
      if (wcnt_q != 16'h0000) begin
         wcnt_d = wcnt_q - 16'h0001;
         if (wcnt_q == 16'h0001) begin
            latch_d = 1'b0;
         end
      end
      if (csn_s) begin
         st_d = asr_pkg::D_CMD;
         cnt_d = 4'h0;
         // commit at chip-select release
         if (pend_q) begin
            nv_d = wdat_q;
            wcnt_d = 16'(`ASR_WR_CYC);
            pend_d = 1'b0;
         end
      end else if (rise) begin
         sh_d = shifted;
         cnt_d = byte_done ? 4'h0 : cnt_q + 4'h1;
         case (st_q)
            asr_pkg::D_CMD: begin
               if (byte_done) begin
                  st_d = asr_pkg::D_SKIP;
                  byt_d = 2'h0;
                  case (shifted)
                     `ASR_CMD_WREN: begin
                        if (!busy) begin
                           latch_d = 1'b1;
                        end
                     end
                     `ASR_CMD_RDREG: begin
                        if (spi || qpi) begin
                           st_d = asr_pkg::D_ADDR;
                           rd_d = 1'b1;
                        end
                     end
                     `ASR_CMD_WRREG: begin
                        if (latch_q && !busy) begin
                           st_d = asr_pkg::D_ADDR;
                           rd_d = 1'b0;
                        end
                     end
                     default: st_d = asr_pkg::D_SKIP;
                  endcase
               end
            end
            asr_pkg::D_ADDR: begin
               if (byte_done) begin
                  byt_d = byt_q + 2'h1;
                  if (byt_q == `ASR_ADDR_BYTES - 2'h1) begin
                     rsel_d = shifted;
                     cnt_d = 4'h0;
                     st_d = rd_q ? asr_pkg::D_DUMMY : asr_pkg::D_IN;
                  end
               end
            end
            asr_pkg::D_DUMMY: begin
               if (cnt_q == dummy - 4'h1) begin
                  cnt_d = 4'h0;
                  obuf_d = regval;
                  st_d = asr_pkg::D_OUT;
               end
            end
            asr_pkg::D_IN: begin
               if (byte_done) begin
                  st_d = asr_pkg::D_SKIP;
                  // status registers are read-only here
                  if (rsel_q == `ASR_REG_NV) begin
                     wdat_d = shifted;
                     pend_d = 1'b1;
                  end
               end
            end
            default: st_d = st_q;
         endcase
      end else if (fall && st_q == asr_pkg::D_OUT) begin
         // rotate so repeated bytes repeat the register
         if (qpi) begin
            io_d = obuf_q[7:4];
            obuf_d = {obuf_q[3:0], obuf_q[7:4]};
         end else begin
            io_d = {2'b00, obuf_q[7], 1'b0};
            obuf_d = {obuf_q[6:0], obuf_q[7]};
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_p_q <= 1'b0;
         st_q <= asr_pkg::D_CMD;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         byt_q <= 2'h0;
         rsel_q <= 8'h00;
         rd_q <= 1'b0;
         obuf_q <= 8'h00;
         io_q <= 4'h0;
         latch_q <= 1'b0;
         nv_q <= `ASR_NV_RST;
         wdat_q <= 8'h00;
         pend_q <= 1'b0;
         wcnt_q <= 16'h0000;
      end else begin
         sclk_p_q <= sclk_s;
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         byt_q <= byt_d;
         rsel_q <= rsel_d;
         rd_q <= rd_d;
         obuf_q <= obuf_d;
         io_q <= io_d;
         latch_q <= latch_d;
         nv_q <= nv_d;
         wdat_q <= wdat_d;
         pend_q <= pend_d;
         wcnt_q <= wcnt_d;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign link.d_io_o = io_q;
   assign link.d_io_oe = (st_q == asr_pkg::D_OUT && !csn_s) ? (qpi ? 4'hF : 4'h2) : 4'h0;
   assign busy_o = busy;
   assign latch_o = latch_q;
   assign nv_cfg_o = nv_q;
endmodule

// >>> logic/asr_host.sv
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_host (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   asr_link_if.host link,
   input wire logic qpi_i,
   input wire logic req_i,
   input asr_pkg::asr_op_t op_i,
   input wire logic [7:0] reg_i,
   input wire logic [7:0] wdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [7:0] rdata_o
);
   logic [3:0] io_s;
   asr_sync #(.W(4), .RST(4'hF)) u_sync (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .d_i(link.io),
      .q_o(io_s)
   );

   asr_pkg::asr_host_st_t st_q, st_d;
   asr_pkg::asr_op_t op_q, op_d;
   logic [7:0] div_q, div_d;
   logic sclk_q, sclk_d;
   logic csn_q, csn_d;
   logic [39:0] tx_q, tx_d;
   logic [3:0] io_q, io_d;
   logic [3:0] oe_q, oe_d;
   logic [7:0] ck_q, ck_d;
   logic [7:0] txc_q, txc_d;
   logic [7:0] rxs_q, rxs_d;
   logic [7:0] tot_q, tot_d;
   logic [7:0] rx_q, rx_d;
   logic poll_q, poll_d;
   logic done_q, done_d;
   logic [7:0] rdata_q, rdata_d;
   logic tick;
   logic launch;
   asr_pkg::asr_op_t lop;
   logic [7:0] lreg;
   logic [7:0] lcmd;
   logic [7:0] nb;
   logic [7:0] cpb;

   assign tick = (div_q == `ASR_HALF - 8'h01);
   assign cpb = {4'h0, qpi_i ? `ASR_CPB_QPI : `ASR_CPB_SPI};

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      div_d = tick ? 8'h00 : div_q + 8'h01;
      sclk_d = sclk_q;
      csn_d = csn_q;
      tx_d = tx_q;
      io_d = io_q;
      oe_d = oe_q;
      ck_d = ck_q;
      txc_d = txc_q;
      rxs_d = rxs_q;
      tot_d = tot_q;
      rx_d = rx_q;
      poll_d = poll_q;
      done_d = 1'b0;
      rdata_d = rdata_q;
      launch = 1'b0;
      lop = op_i;
      lreg = reg_i;
      lcmd = `ASR_CMD_NONE;
      nb = 8'h01;
      case (st_q)
         asr_pkg::H_IDLE: begin
            div_d = 8'h00;
            launch = req_i;
         end
         asr_pkg::H_RUN: begin
            if (tick && !sclk_q) begin
               sclk_d = 1'b1;
               ck_d = ck_q + 8'h01;
               if (ck_q >= rxs_q) begin
                  rx_d = qpi_i ? {rx_q[3:0], io_s} : {rx_q[6:0], io_s[1]};
               end
            end else if (tick) begin
               sclk_d = 1'b0;
               if (ck_q == tot_q) begin
                  st_d = asr_pkg::H_END;
               end else begin
                  io_d = qpi_i ? tx_q[39:36] : {3'b000, tx_q[39]};
                  tx_d = qpi_i ? {tx_q[35:0], 4'h0} : {tx_q[38:0], 1'b0};
                  if (ck_q == txc_q) begin
                     oe_d = 4'h0;
                  end
               end
            end
         end
         asr_pkg::H_END: begin
            if (tick) begin
               csn_d = 1'b1;
               oe_d = 4'h0;
               st_d = asr_pkg::H_GAP;
            end
         end
         asr_pkg::H_GAP: begin
            if (tick) begin
               // wait out the busy flag after a write
               if ((op_q == asr_pkg::OP_WRITE && !poll_q)
                   || (poll_q && rx_q[`ASR_BIT_BUSY])) begin
                  launch = 1'b1;
                  lop = asr_pkg::OP_READ;
                  lreg = `ASR_REG_SR1;
                  poll_d = 1'b1;
               end else begin
                  done_d = 1'b1;
                  rdata_d = rx_q;
                  poll_d = 1'b0;
                  st_d = asr_pkg::H_IDLE;
               end
            end
         end
         default: st_d = asr_pkg::H_IDLE;
      endcase
      if (launch) begin
         case (lop)
            asr_pkg::OP_READ: begin
               lcmd = `ASR_CMD_RDREG;
               nb = 8'h04;
            end
            asr_pkg::OP_WRITE: begin
               lcmd = `ASR_CMD_WRREG;
               nb = 8'h05;
            end
            default: begin
               lcmd = `ASR_CMD_WREN;
               nb = 8'h01;
            end
         endcase
         if (!poll_d) begin
            op_d = lop;
         end
         // address bytes 00 00 reg: selector last
         tx_d = {lcmd, 16'h0000, lreg, wdata_i};
         io_d = qpi_i ? lcmd[7:4] : {3'b000, lcmd[7]};
         tx_d = qpi_i ? {tx_d[35:0], 4'h0} : {tx_d[38:0], 1'b0};
         oe_d = qpi_i ? 4'hF : 4'h1;
         csn_d = 1'b0;
         sclk_d = 1'b0;
         ck_d = 8'h00;
         div_d = 8'h00;
         txc_d = 8'(nb * cpb);
         rxs_d = 8'(nb * cpb) + ((lop == asr_pkg::OP_READ)
                 ? {4'h0, qpi_i ? `ASR_DUMMY_QPI : `ASR_DUMMY_SPI} : 8'h00);
         tot_d = rxs_d + ((lop == asr_pkg::OP_READ) ? cpb : 8'h00);
         st_d = asr_pkg::H_RUN;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q <= asr_pkg::H_IDLE;
         op_q <= asr_pkg::OP_WREN;
         div_q <= 8'h00;
         sclk_q <= 1'b0;
         csn_q <= 1'b1;
         tx_q <= 40'h0;
         io_q <= 4'h0;
         oe_q <= 4'h0;
         ck_q <= 8'h00;
         txc_q <= 8'h00;
         rxs_q <= 8'h00;
         tot_q <= 8'h00;
         rx_q <= 8'h00;
         poll_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         div_q <= div_d;
         sclk_q <= sclk_d;
         csn_q <= csn_d;
         tx_q <= tx_d;
         io_q <= io_d;
         oe_q <= oe_d;
         ck_q <= ck_d;
         txc_q <= txc_d;
         rxs_q <= rxs_d;
         tot_q <= tot_d;
         rx_q <= rx_d;
         poll_q <= poll_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   assign link.sclk = sclk_q;
   assign link.cs_n = csn_q;
   assign link.h_io_o = io_q;
   assign link.h_io_oe = oe_q;
   assign ready_o = (st_q == asr_pkg::H_IDLE);
   assign done_o = done_q;
   assign rdata_o = rdata_q;
endmodule

// >>> tb/asr_link_monitor.sv
`timescale 1ns/1ps
module asr_link_monitor (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] h_io_o,
   input wire logic [3:0] h_io_oe,
   input wire logic [3:0] d_io_o,
   input wire logic [3:0] d_io_oe,
   input wire logic [3:0] io
);
   logic sclk_q;
   logic [7:0] rises_q;
   logic [7:0] rises_d;
   // ---------------------------------------------
   // rising clock edges counted per frame
   // ---------------------------------------------
   always_comb begin
      rises_d = rises_q;
      if (cs_n) begin
         rises_d = 8'h00;
      end else if (sclk && !sclk_q) begin
         rises_d = rises_q + 8'h01;
      end
   end
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_q <= 1'b0;
         rises_q <= 8'h00;
      end else begin
         sclk_q <= sclk;
         rises_q <= rises_d;
      end
   end
   // ---------------------------------------------
   // link checks
   // ---------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   sclk_high_a: assert property ($rose(sclk) |=> sclk [*7] ##1 !sclk)
      else $error("serial clock high phase not eight cycles");
   sclk_low_a: assert property ($fell(sclk) && !cs_n |=> !sclk [*7] ##1 (sclk || cs_n))
      else $error("serial clock low phase not eight cycles");
   frame_len_a: assert property ($rose(cs_n) |->
      rises_q inside {8'h02, 8'h08, 8'h0A, 8'h0B, 8'h28, 8'h30})
      else $error("frame clock count not a legal command length");
   no_clash_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
      else $error("host and device drive the same line");
   dev_release_a: assert property (cs_n && $past(cs_n, 5) |-> d_io_oe == 4'h0)
      else $error("device drives lines while deselected");
   dev_lanes_a: assert property (d_io_oe inside {4'h0, 4'h2, 4'hF})
      else $error("device drives an illegal set of lines");
   data_stable_a: assert property (sclk && $past(sclk) |->
      $stable(h_io_o) && $stable(d_io_o))
      else $error("data changed while serial clock high");
   idle_clock_a: assert property (cs_n |-> !sclk)
      else $error("serial clock toggles outside a frame");
   idle_lines_a: assert property (cs_n && $past(cs_n, 5) |-> io == 4'hF)
      else $error("data lines not released while deselected");
   qpi_read_c: cover property (d_io_oe == 4'hF);
   spi_read_c: cover property (d_io_oe == 4'h2);
   qpi_write_c: cover property ($rose(cs_n) && rises_q == 8'h0A);
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "asr_map.svh"
module tb_top;
   logic ref_clk_i;
   logic resetn_i;
   asr_pkg::asr_mode_t mode;
   asr_pkg::asr_op_t op;
   logic array_busy;
   logic qpi;
   logic req;
   logic [7:0] sel;
   logic [7:0] wdata;
   logic ready;
   logic done;
   logic [7:0] rdata;
   logic busy;
   logic latch;
   logic [7:0] nv_cfg;
   logic saw_busy;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   asr_link_if link ();
   asr_dev u_asr_dev (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link.dev),
      .mode_i(mode), .array_busy_i(array_busy), .busy_o(busy), .latch_o(latch),
      .nv_cfg_o(nv_cfg));
   asr_host u_asr_host (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link.host),
      .qpi_i(qpi), .req_i(req), .op_i(op), .reg_i(sel), .wdata_i(wdata),
      .ready_o(ready), .done_o(done), .rdata_o(rdata));
   asr_link_monitor u_asr_link_monitor (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .sclk(link.sclk), .cs_n(link.cs_n), .h_io_o(link.h_io_o), .h_io_oe(link.h_io_oe),
      .d_io_o(link.d_io_o), .d_io_oe(link.d_io_oe), .io(link.io));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         $display("Error run_time expected end seen hang");
         tally_and_finish();
      end
   end
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic host_op(input asr_pkg::asr_mode_t m, input asr_pkg::asr_op_t o,
         input logic [7:0] r, input logic [7:0] w);
      int n;
      n = 0;
      while (ready !== 1'b1) begin
         @(posedge ref_clk_i);
         #1;
      end
      mode = m;
      qpi = (m != asr_pkg::M_SPI);
      op = o;
      sel = r;
      wdata = w;
      req = 1'b1;
      saw_busy = 1'b0;
      @(posedge ref_clk_i);
      #1;
      req = 1'b0;
      chk("ready_o taken", {7'h00, ready}, 8'h00);
      do begin
         @(posedge ref_clk_i);
         #1;
         if (busy === 1'b1) saw_busy = 1'b1;
         n++;
      end while (done !== 1'b1 && n < 20000);
      chk("done_o", {7'h00, done}, 8'h01);
      chk("ready_o after done", {7'h00, ready}, 8'h01);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic s_reset();
      chk("latch_o", {7'h00, latch}, 8'h00);
      chk("nv_cfg_o", nv_cfg, `ASR_NV_RST);
      chk("busy_o", {7'h00, busy}, 8'h00);
   endtask
   task automatic s_status();
      host_op(asr_pkg::M_SPI, asr_pkg::OP_READ, `ASR_REG_SR1, 8'h00);
      chk("status idle", rdata, 8'h00);
      array_busy = 1'b1;
      host_op(asr_pkg::M_QPI, asr_pkg::OP_READ, `ASR_REG_SR1, 8'h00);
      chk("status busy quad", rdata, 8'h01);
      host_op(asr_pkg::M_SPI, asr_pkg::OP_READ, `ASR_REG_SR1, 8'h00);
      chk("status busy single", rdata, 8'h01);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WREN, 8'h00, 8'h00);
      chk("latch while busy", {7'h00, latch}, 8'h00);
      array_busy = 1'b0;
      host_op(asr_pkg::M_QPI, asr_pkg::OP_READ, 8'h7F, 8'h00);
      chk("unmapped read", rdata, 8'h00);
   endtask
   task automatic s_latch();
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WREN, 8'h00, 8'h00);
      chk("latch set", {7'h00, latch}, 8'h01);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_READ, `ASR_REG_SR1, 8'h00);
      chk("status latch quad", rdata, 8'h02);
      host_op(asr_pkg::M_SPI, asr_pkg::OP_READ, `ASR_REG_SR1, 8'h00);
      chk("status latch single", rdata, 8'h02);
   endtask
   task automatic s_write_nv();
      host_op(asr_pkg::M_SPI, asr_pkg::OP_WRITE, `ASR_REG_NV, 8'hA5);
      chk("busy seen", {7'h00, saw_busy}, 8'h01);
      chk("nv after write", nv_cfg, 8'hA5);
      chk("latch after write", {7'h00, latch}, 8'h00);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_READ, `ASR_REG_NV, 8'h00);
      chk("nv read quad", rdata, 8'hA5);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WREN, 8'h00, 8'h00);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WRITE, `ASR_REG_NV, 8'h3C);
      chk("nv quad write", nv_cfg, 8'h3C);
      host_op(asr_pkg::M_SPI, asr_pkg::OP_READ, `ASR_REG_NV, 8'h00);
      chk("nv read single", rdata, 8'h3C);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WRITE, `ASR_REG_NV, 8'h5A);
      chk("nv write no latch", nv_cfg, 8'h3C);
      chk("no busy no latch", {7'h00, saw_busy}, 8'h00);
   endtask
   task automatic s_write_ro();
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WREN, 8'h00, 8'h00);
      host_op(asr_pkg::M_QPI, asr_pkg::OP_WRITE, `ASR_REG_SR1, 8'hFF);
      chk("status write busy", {7'h00, saw_busy}, 8'h00);
      chk("nv after status write", nv_cfg, 8'h3C);
   endtask
   task automatic s_modes();
      asr_pkg::asr_mode_t ml[4] = '{asr_pkg::M_DUAL, asr_pkg::M_QDTR, asr_pkg::M_OCT,
         asr_pkg::M_OCTDTR};
      foreach (ml[i]) begin
         host_op(ml[i], asr_pkg::OP_READ, `ASR_REG_NV, 8'h00);
         chk("read in unserved mode", rdata, 8'hFF);
      end
      host_op(asr_pkg::M_QPI, asr_pkg::OP_READ, `ASR_REG_NV, 8'h00);
      chk("read back in quad", rdata, 8'h3C);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      resetn_i = 1'b0;
      mode = asr_pkg::M_SPI;
      op = asr_pkg::OP_READ;
      array_busy = 1'b0;
      qpi = 1'b0;
      req = 1'b0;
      sel = 8'h00;
      wdata = 8'h00;
      saw_busy = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      resetn_i = 1'b1;
      s_reset();
      s_status();
      s_latch();
      s_write_nv();
      s_write_ro();
      s_modes();
      tally_and_finish();
   end
endmodule
